//--- inc/rfa_consts.svh
// Offsets, widths, reset values and sizes of the register field access bank.
`ifndef RFA_CONSTS_SVH
`define RFA_CONSTS_SVH

// Word and address widths and source count of the internal access port.
`define RFA_DW            16
`define RFA_AW            4
`define RFA_NSRC          3

// Word offsets of the field-type registers.
`define RFA_OFS_RO        4'h0
`define RFA_OFS_RC        4'h1
`define RFA_OFS_WO        4'h2
`define RFA_OFS_W1C       4'h3
`define RFA_OFS_W0C       4'h4
`define RFA_OFS_LATCH     4'h5
`define RFA_OFS_SC        4'h6
`define RFA_OFS_RSVD      4'h7

// Field layout of the latch register.
`define RFA_LATCH_W       8
`define RFA_LL_LSB        0
`define RFA_LH_LSB        8

// Reset values.
`define RFA_RST_WORD      16'h0000
`define RFA_RST_LL        8'hFF
`define RFA_RST_LH        8'h00
`define RFA_RST_W0C       16'h0000

// Management source indices, highest priority first.
`define RFA_SRC_SPI       0
`define RFA_SRC_I2C       1
`define RFA_SRC_INB       2

`endif

//--- inc/rfa_pkg.sv
// Types shared by the register field access bank and its source arbiter.
`include "rfa_consts.svh"

package rfa_pkg;

	typedef logic [`RFA_DW-1:0]   rfa_word_t;
	typedef logic [`RFA_AW-1:0]   rfa_addr_t;
	typedef logic [`RFA_NSRC-1:0] rfa_src_mask_t;

	// One register access request from a management interface.
	typedef struct packed {
		logic      valid;
		logic      write;
		rfa_addr_t addr;
		rfa_word_t wdata;
	} rfa_req_t;

	// Requests of all management sources side by side.
	typedef rfa_req_t [`RFA_NSRC-1:0] rfa_req_vec_t;

endpackage : rfa_pkg

//--- verilog/rfa_arb.sv
// Fixed-priority arbiter that funnels the management sources onto one access.
`timescale 1ns/100ps
`default_nettype none
`include "rfa_consts.svh"

module rfa_arb (
	// Clock and reset.
	input  wire logic               clock_i,
	input  wire logic               srst_i,
	// Requests from the management sources.
	input  wire rfa_pkg::rfa_req_vec_t req_i,
	// Selected access, held one cycle while the bank performs it.
	output var  rfa_pkg::rfa_req_t  acc_o,
	output var  rfa_pkg::rfa_src_mask_t acc_src_o
);
	import rfa_pkg::*;

	rfa_req_t      acc_q;
	rfa_src_mask_t src_q;

	// A new request is taken only while no access is in flight, so a source
	// that still holds valid until its answer shows is never taken twice.
	always_ff @(posedge clock_i) begin
		if (srst_i) begin
			acc_q <= '0;
			src_q <= '0;
		end else if (acc_q.valid) begin
			acc_q <= '0;
			src_q <= '0;
		end else begin
			acc_q <= '0;
			src_q <= '0;
			for (int i = `RFA_NSRC - 1; i >= 0; i--) begin
				if (req_i[i].valid) begin
					acc_q    <= req_i[i];
					src_q    <= '0;
					src_q[i] <= 1'b1;
				end
			end
		end
	end

	assign acc_o     = acc_q;
	assign acc_src_o = src_q;

endmodule : rfa_arb

`default_nettype wire

//--- verilog/rfa_bank.sv
// Register bank that shows each register field access type.
//
// Function
// - Read-only field returns its live value; writes leave it unchanged.
// - Read-clear field returns contents, then clears; writes have no effect.
// - Write-only field stores writes; its read value is unspecified.
// - Write-one-clear: ones written clear bits, zeros written keep them.
// - Write-zero-clear: zeros written clear bits, ones written keep them.
// - Latch-low bit stays low until read, then follows the condition again.
// - Latch-high bit stays high until read, then follows the condition again.
// - Self-clearing bit set by writing one, clears itself when action completes.
// - Register space reachable from SPI, I2C and in-band management sources.
`timescale 1ns/100ps
`default_nettype none
`include "rfa_consts.svh"

module rfa_bank (
	// Clock and reset.
	input  wire logic                   clock_i,
	input  wire logic                   srst_i,
	// Access requests from the SPI, I2C and in-band management sources.
	input  wire rfa_pkg::rfa_req_vec_t  req_i,
	output logic [`RFA_NSRC-1:0]        ack_o,
	output var  rfa_pkg::rfa_word_t     rdata_o,
	// Live status pins, asynchronous to the clock.
	input  wire rfa_pkg::rfa_word_t     status_pin_i,
	input  wire logic [`RFA_LATCH_W-1:0] link_pin_i,
	input  wire logic [`RFA_LATCH_W-1:0] fault_pin_i,
	// Hardware event pulses from logic on the same clock.
	input  wire rfa_pkg::rfa_word_t     rc_event_i,
	input  wire rfa_pkg::rfa_word_t     w1c_event_i,
	input  wire rfa_pkg::rfa_word_t     w0c_event_i,
	// Self-clearing actions: request out, completion in.
	output var  rfa_pkg::rfa_word_t     act_req_o,
	input  wire rfa_pkg::rfa_word_t     act_done_i,
	// Control word written through the write-only register.
	output var  rfa_pkg::rfa_word_t     ctrl_o
);
	import rfa_pkg::*;

	// Sticky update: keep, clear the masked bits, then let new sets win.
	// Putting the set term last is what makes a hardware event beat a clear
	// that lands in the same cycle, so no event is ever lost.
	function automatic rfa_word_t sticky(input rfa_word_t cur,
	                                     input rfa_word_t clr,
	                                     input rfa_word_t set);
		sticky = (cur & ~clr) | set;
	endfunction : sticky

	// Read or write strobe for one register offset.
	function automatic logic hit(input rfa_req_t a, input rfa_addr_t ofs, input logic wr);
		hit = a.valid && (a.write == wr) && (a.addr == ofs);
	endfunction : hit

	rfa_req_t                 acc;
	rfa_src_mask_t            acc_src;
	rfa_word_t                st_meta_q, st_q;
	logic [`RFA_LATCH_W-1:0]  ln_meta_q, ln_q, ft_meta_q, ft_q;
	rfa_word_t                rc_q, wo_q, w1c_q, w0c_q, sc_q;
	logic [`RFA_LATCH_W-1:0]  ll_q, lh_q;
	rfa_word_t                rd_d, rdata_q;
	logic [`RFA_NSRC-1:0]     ack_q;
	rfa_word_t                rc_clr, w1c_clr, w0c_clr, sc_set;

	// One access at a time from whichever source is granted.
	// Serialising here keeps every field free of multi-writer conflicts.
	rfa_arb u_arb (
		.clock_i   (clock_i),
		.srst_i    (srst_i),
		.req_i     (req_i),
		.acc_o     (acc),
		.acc_src_o (acc_src)
	);

	// Two-stage synchronisers for the pin inputs; only the second stage is read.
	// Bits are synchronised one by one, so a multi-bit status word may show a
	// mix of old and new bits for one cycle while it changes.
	always_ff @(posedge clock_i) begin
		if (srst_i) begin
			st_meta_q <= `RFA_RST_WORD;
			st_q      <= `RFA_RST_WORD;
			ln_meta_q <= `RFA_RST_LL;
			ln_q      <= `RFA_RST_LL;
			ft_meta_q <= `RFA_RST_LH;
			ft_q      <= `RFA_RST_LH;
		end else begin
			st_meta_q <= status_pin_i;
			st_q      <= st_meta_q;
			ln_meta_q <= link_pin_i;
			ln_q      <= ln_meta_q;
			ft_meta_q <= fault_pin_i;
			ft_q      <= ft_meta_q;
		end
	end

	// Clear and set masks derived from the current access.
	// Each mask is zero unless the access is of the right kind and offset,
	// so a write never disturbs a read-clear field and a read never a write-clear.
	always_comb begin
		rc_clr  = hit(acc, `RFA_OFS_RC, 1'b0) ? '1 : '0;
		w1c_clr = hit(acc, `RFA_OFS_W1C, 1'b1) ? acc.wdata : '0;
		w0c_clr = hit(acc, `RFA_OFS_W0C, 1'b1) ? ~acc.wdata : '0;
		sc_set  = hit(acc, `RFA_OFS_SC, 1'b1) ? acc.wdata : '0;
	end

	// Read-clear field; a write here is ignored.
	// The read data is taken from the old contents in the same edge.
	always_ff @(posedge clock_i) begin
		if (srst_i) begin
			rc_q <= `RFA_RST_WORD;
		end else begin
			rc_q <= sticky(rc_q, rc_clr, rc_event_i);
		end
	end

	// Write-one-clear status field. Software acknowledges only the bits it
	// has handled, so events it has not seen yet stay visible.
	always_ff @(posedge clock_i) begin
		if (srst_i) begin
			w1c_q <= `RFA_RST_WORD;
		end else begin
			w1c_q <= sticky(w1c_q, w1c_clr, w1c_event_i);
		end
	end

	// Write-zero-clear status field. The inverted sense lets software keep
	// a chosen set of bits by writing that set as ones.
	always_ff @(posedge clock_i) begin
		if (srst_i) begin
			w0c_q <= `RFA_RST_W0C;
		end else begin
			w0c_q <= sticky(w0c_q, w0c_clr, w0c_event_i);
		end
	end

	// Write-only control word; it steers the ctrl output directly.
	always_ff @(posedge clock_i) begin
		if (srst_i) begin
			wo_q <= `RFA_RST_WORD;
		end else if (hit(acc, `RFA_OFS_WO, 1'b1)) begin
			wo_q <= acc.wdata;
		end
	end

	// Self-clearing action bits: a write of one starts an action, completion
	// clears it. A fresh start beats a completion in the same cycle so a
	// re-trigger is never dropped; writes of zero do nothing.
	always_ff @(posedge clock_i) begin
		if (srst_i) begin
			sc_q <= `RFA_RST_WORD;
		end else begin
			sc_q <= sticky(sc_q, act_done_i, sc_set);
		end
	end

	// Latch-low bits. A drop of the synced condition is held until the host
	// reads the latch word; the read reloads the live condition, so a bit that
	// recovered reads high again afterwards, while a drop that coincides with
	// the read edge still shows low on the next read.
	always_ff @(posedge clock_i) begin
		if (srst_i) begin
			ll_q <= `RFA_RST_LL;
		end else if (hit(acc, `RFA_OFS_LATCH, 1'b0)) begin
			ll_q <= ln_q;
		end else begin
			ll_q <= ll_q & ln_q;
		end
	end

	// Latch-high bits, the mirror image: a rise is held until read. A short
	// fault pulse shorter than one clock may be missed by the synchroniser.
	always_ff @(posedge clock_i) begin
		if (srst_i) begin
			lh_q <= `RFA_RST_LH;
		end else if (hit(acc, `RFA_OFS_LATCH, 1'b0)) begin
			lh_q <= ft_q;
		end else begin
			lh_q <= lh_q | ft_q;
		end
	end

	// Read multiplexer. Unmapped, reserved and write-only words read as zero.
	// A fixed zero keeps reserved reads from leaking internal state.
	always_comb begin
		rd_d = '0;
		unique case (acc.addr)
			`RFA_OFS_RO:    rd_d = st_q;
			`RFA_OFS_RC:    rd_d = rc_q;
			`RFA_OFS_W1C:   rd_d = w1c_q;
			`RFA_OFS_W0C:   rd_d = w0c_q;
			`RFA_OFS_LATCH: rd_d = {lh_q, ll_q};
			`RFA_OFS_SC:    rd_d = sc_q;
			default:        rd_d = '0;
		endcase
	end

	// Answer register: one-cycle acknowledge to the granted source, read data
	// held until the next access so late samplers still see it.
	// A write answers with zero data so a host never mistakes it for a read.
	always_ff @(posedge clock_i) begin
		if (srst_i) begin
			ack_q   <= '0;
			rdata_q <= `RFA_RST_WORD;
		end else begin
			ack_q <= acc_src;
			if (acc.valid) begin
				rdata_q <= acc.write ? `RFA_RST_WORD : rd_d;
			end
		end
	end

	assign ack_o     = ack_q;
	assign rdata_o   = rdata_q;
	assign act_req_o = sc_q;
	assign ctrl_o    = wo_q;

endmodule : rfa_bank

`default_nettype wire

//--- tb/rfa_bank_props.sv
// Concurrent checks on the ports of the register field access bank.
`timescale 1ns/100ps
`default_nettype none
`include "rfa_consts.svh"
module rfa_bank_props (
	// Clock and reset.
	input wire logic                    clock_i,
	input wire logic                    srst_i,
	// Access port.
	input wire rfa_pkg::rfa_req_vec_t   req_i,
	input wire logic [`RFA_NSRC-1:0]    ack_o,
	input wire rfa_pkg::rfa_word_t      rdata_o,
	// Action and control words.
	input wire rfa_pkg::rfa_word_t      act_req_o,
	input wire rfa_pkg::rfa_word_t      act_done_i,
	input wire rfa_pkg::rfa_word_t      ctrl_o
);
	import rfa_pkg::*;
	rfa_req_t r0_q;
	logic     rst_q;
	logic     wr_ack;
	logic     quiet;
	default clocking @(posedge clock_i); endclocking
	default disable iff (srst_i);
	// Last sampled request of source 0 and reset, so holds are not judged across a reset.
	always_ff @(posedge clock_i) begin
		r0_q <= req_i[0];
		rst_q <= srst_i;
	end
	// A write from source 0 is answered now; quiet means no answer and no reset just before.
	assign wr_ack = ack_o[0] && r0_q.write;
	assign quiet = ack_o == '0 && !rst_q;
	ack_onehot_a: assert property ($onehot0(ack_o))
		else $error("two sources answered at once");
	ack_pulse_a: assert property (ack_o != '0 |=> ack_o == '0)
		else $error("answer lasted more than one cycle");
	ack_cause_a: assert property (ack_o[0] |-> $past(req_i[0].valid, 2))
		else $error("answer without a request");
	rdata_hold_a: assert property (quiet |-> $stable(rdata_o))
		else $error("read data moved without an access");
	ctrl_load_a: assert property (wr_ack && r0_q.addr == `RFA_OFS_WO |-> ctrl_o == r0_q.wdata)
		else $error("control word not loaded by write");
	ctrl_hold_a: assert property (quiet |-> $stable(ctrl_o))
		else $error("control word moved without a write");
	sc_set_a: assert property (wr_ack && r0_q.addr == `RFA_OFS_SC
		|-> (act_req_o & r0_q.wdata) == r0_q.wdata)
		else $error("action bit not set by write of one");
	sc_done_a: assert property (act_done_i != '0
		|=> (act_req_o & $past(act_done_i)) == '0 || ack_o != '0)
		else $error("action bit stayed after completion");
	sc_rise_a: assert property (!rst_q && (act_req_o & ~$past(act_req_o)) != '0 |-> ack_o != '0)
		else $error("action bit rose without a write");
endmodule : rfa_bank_props
bind rfa_bank rfa_bank_props u_props (.clock_i(clock_i), .srst_i(srst_i), .req_i(req_i),
	.ack_o(ack_o), .rdata_o(rdata_o), .act_req_o(act_req_o), .act_done_i(act_done_i),
	.ctrl_o(ctrl_o));
`default_nettype wire

//--- tb/rfa_host.sv
// Behavioural host that issues register accesses on one management source.
`timescale 1ns/100ps
`default_nettype none
module rfa_host (
	// Clock and answer from the bank.
	input  wire logic               clock_i,
	input  wire logic               ack_i,
	input  wire rfa_pkg::rfa_word_t rdata_i,
	// Request towards the bank.
	output var  rfa_pkg::rfa_req_t  req_o
);
	import rfa_pkg::*;
	// Idle requests are all zeros, so no stray reserved bits go out.
	initial req_o = '0;
	// One cycle of spacing first, then the request holds until the answer shows or 20 cycles pass.
	task automatic xfer(input logic w, input rfa_addr_t a, input rfa_word_t d,
		output rfa_word_t q);
		@(posedge clock_i);
		#1 req_o = '{1'b1, w, a, d};
		for (int i = 0; i < 20 && !ack_i; i++) begin
			@(posedge clock_i);
			#1;
		end
		q = rdata_i;
		req_o = '0;
	endtask : xfer
endmodule : rfa_host
`default_nettype wire

//--- tb/tb.sv
// Self-checking bench for the register field access bank.
`timescale 1ns/100ps
`default_nettype none
module tb;
	import rfa_pkg::*;
	typedef struct {logic w; rfa_addr_t a; rfa_word_t d, e, x;} rfa_row_t;
	logic         clock_i = 1'b0;
	logic         srst_i = 1'b1;
	wire rfa_req_vec_t req;
	logic [2:0]   ack;
	rfa_word_t    rdata, act_req, ctrl, r, q[3];
	rfa_word_t    rc_ev = '0, w1c_ev = '0, w0c_ev = '0, done = '0, stat = 16'hA5A5;
	logic [7:0]   link = 8'hFF, fault = 8'h00;
	int           n_mismatch = 0, compares = 0;
	// Reserved offsets never appear here.
	rfa_row_t rows[14] = '{'{1'b0, 4'h5, '0, '0, 16'h00FF}, '{1'b0, 4'h0, '0, '0, 16'hA5A5},
		'{1'b1, 4'h0, 16'hFFFF, '0, '0}, '{1'b0, 4'h0, '0, '0, 16'hA5A5},
		'{1'b1, 4'h1, '0, 16'h0F0F, '0}, '{1'b0, 4'h1, '0, '0, 16'h0F0F},
		'{1'b0, 4'h1, '0, '0, '0},
		'{1'b0, 4'h3, '0, '0, 16'h0F0F}, '{1'b1, 4'h3, 16'h0303, '0, '0},
		'{1'b0, 4'h3, '0, '0, 16'h0C0C}, '{1'b0, 4'h4, '0, '0, 16'h0F0F},
		'{1'b1, 4'h4, 16'hFF0C, '0, '0}, '{1'b0, 4'h4, '0, '0, 16'h0F0C},
		'{1'b1, 4'h2, 16'hBEEF, '0, '0}};
	rfa_bank uut (.clock_i(clock_i), .srst_i(srst_i), .req_i(req), .ack_o(ack),
		.rdata_o(rdata), .status_pin_i(stat), .link_pin_i(link), .fault_pin_i(fault),
		.rc_event_i(rc_ev), .w1c_event_i(w1c_ev), .w0c_event_i(w0c_ev),
		.act_req_o(act_req), .act_done_i(done), .ctrl_o(ctrl));
	rfa_host h0 (.clock_i(clock_i), .ack_i(ack[0]), .rdata_i(rdata), .req_o(req[0]));
	rfa_host h1 (.clock_i(clock_i), .ack_i(ack[1]), .rdata_i(rdata), .req_o(req[1]));
	rfa_host h2 (.clock_i(clock_i), .ack_i(ack[2]), .rdata_i(rdata), .req_o(req[2]));
	always #5 clock_i = ~clock_i;
	task automatic check(input rfa_word_t s, input rfa_word_t e);
		compares++;
		if (s !== e) begin
			n_mismatch++;
			$display("unexpected at %0t: seen %h expected %h", $time, s, e);
		end
	endtask : check
	// Events pulse on the read-clear, write-one-clear and write-zero-clear fields for exactly one cycle.
	task automatic ev(input rfa_word_t e);
		{rc_ev, w1c_ev, w0c_ev} = {e, e, e};
		@(posedge clock_i);
		#1 {rc_ev, w1c_ev, w0c_ev} = '0;
	endtask : ev
	task automatic give_verdict();
		$display("compares %0d n_mismatch %0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : give_verdict
	// A hang ends the run long after the tests should have finished.
	initial begin
		#100000 n_mismatch++;
		give_verdict();
	end
	// Table rows first, then the latch, action, event race and shared access cases.
	initial begin
		repeat (8) @(posedge clock_i);
		check(ctrl, '0);
		check(act_req, '0);
		#1 srst_i = 1'b0;
		foreach (rows[i]) begin
			if (rows[i].e != '0) ev(rows[i].e);
			h0.xfer(rows[i].w, rows[i].a, rows[i].d, r);
			check(r, rows[i].x);
		end
		check(ctrl, 16'hBEEF);
		link = 8'hFE;
		repeat (4) @(posedge clock_i);
		#1 {link, fault} = 16'hFF01;
		repeat (4) @(posedge clock_i);
		#1 fault = 8'h00;
		repeat (4) @(posedge clock_i);
		h0.xfer(1'b0, 4'h5, '0, r);
		check(r, 16'h01FE);
		h0.xfer(1'b0, 4'h5, '0, r);
		check(r, 16'h00FF);
		h0.xfer(1'b1, 4'h6, 16'h0005, r);
		check(act_req, 16'h0005);
		h0.xfer(1'b1, 4'h6, '0, r);
		h0.xfer(1'b0, 4'h6, '0, r);
		check(r, 16'h0005);
		done = 16'h0001;
		@(posedge clock_i);
		#1 done = '0;
		check(act_req, 16'h0004);
		// The event lands on the very edge where the read clears the field.
		fork
			h1.xfer(1'b0, 4'h1, '0, q[1]);
			begin
				repeat (2) @(posedge clock_i);
				#1 ev(16'h8001);
			end
		join
		check(q[1], '0);
		h1.xfer(1'b0, 4'h1, '0, r);
		check(r, 16'h8001);
		// The status pin moves, and every source must read the new live value.
		stat = 16'h5A5A;
		fork
			h0.xfer(1'b0, 4'h0, '0, q[0]);
			h1.xfer(1'b0, 4'h0, '0, q[1]);
			h2.xfer(1'b0, 4'h0, '0, q[2]);
		join
		foreach (q[i]) check(q[i], 16'h5A5A);
		// A reset in mid-run returns every output and sticky field to rest.
		srst_i = 1'b1;
		repeat (2) @(posedge clock_i);
		#1 srst_i = 1'b0;
		check(ctrl, '0);
		check(act_req, '0);
		check(rdata, '0);
		h0.xfer(1'b0, 4'h3, '0, r);
		check(r, '0);
		h0.xfer(1'b0, 4'h5, '0, r);
		check(r, 16'h00FF);
		give_verdict();
	end
endmodule : tb
`default_nettype wire
